//--- lapbs_link_supervision.sv
// Link supervision: error counters, response timer, address and control registers, abort, loop-back
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Five saturating 8-bit counters after lookup table
// R2: Counter one counts frame check errors, aborts
// R3: Counter two counts frames under 32 bits
// R4: Counter three counts timer run-outs on commands
// R5: Counters one, five need matching address
// R6: Updates via transmit DMA, last wins
// R7: Counters update only while link up
// R8: Register seven captures good matching control field
// R9: Registers eight, nine: timer, retry limit
// R10: Delay is count times 16384 clocks
// R11: Timer, limit kept across time-outs
// R12: Information frames start, restart, stop timer
// R13: Received not-ready restarts timer while up
// R14: Set-mode/disconnect start; acknowledge, DM stop
// R15: Receiver idle starts, stops, restarts timer
// R16: Host sets addresses 01/03 per role
// R17: Network commands use 03, terminal 01
// R18: Expiry resends command with poll, limited
// R19: Exhausted: command to set-mode, to disconnect
// R20: Bit 0 first, standard control codes
// R21: Only reject reports, information carry data
// R22: Reject sent as response, accepted both
// R23: Abort seven ones on underrun, reject
// R24: Loop-back routes transmit data and clock
// R25: Host sets equal addresses for loop-back
module lapbs_link_supervision #(
	parameter int TICK_CYCLES = lapbs_pkg::T1_UNIT_CYCLES
) (
	input  wire logic               CLK_SYS_IN,
	input  wire logic               RST_N_IN,
	input  wire logic               CS_N_IN,
	input  wire logic               WE_N_IN,
	input  wire logic               RE_N_IN,
	input  wire logic [3:0]         ADDR_IN,
	input  wire logic [7:0]         DAL_IN,
	output logic      [7:0]         DAL_OUT,
	output logic                    DAL_OE_OUT,
	output logic                    REPLY_N_OUT,
	input  wire lapbs_pkg::lapbs_rxev_s RX_EVENT_IN,
	input  wire lapbs_pkg::lapbs_txev_s TX_EVENT_IN,
	input  wire logic               ACK_SOME_IN,
	input  wire logic               ACK_ALL_IN,
	input  wire logic               LINK_DOWN_IN,
	input  wire logic               FRMR_WAIT_IN,
	input  wire logic               TX_BUSY_IN,
	input  wire logic               TX_PKT_ACTIVE_IN,
	input  wire logic               RECEIVER_IDLE_FLAG_IN,
	input  wire logic               LOOPBACK_SELECT_BIT_IN,
	output logic                    DMA_REQ_OUT,
	output logic                    DMA_WE_OUT,
	output logic      [15:0]        DMA_ADDR_OUT,
	output logic      [7:0]         DMA_WDATA_OUT,
	input  wire logic               DMA_ACK_IN,
	input  wire logic [7:0]         DMA_RDATA_IN,
	output logic                    RETX_REQ_OUT,
	output var lapbs_pkg::lapbs_kind_e RETX_KIND_OUT,
	output logic                    ERROR_IRQ_OUT,
	output logic                    RX_CLK_FROM_TX_OUT,
	input  wire logic               TX_BIT_CLOCK_IN,
	input  wire logic               TX_DATA_IN,
	input  wire logic               TX_UNDERRUN_IN,
	input  wire logic               RX_LINE_IN,
	output logic                    SERIAL_TX_LINE_OUT,
	output logic                    RX_DATA_OUT
);
	import lapbs_pkg::*;

	// ***********************************
	// Register port
	// ***********************************
	logic [14:0] bus_s1_r, bus_s2_r;
	logic        wr_d_r;
	logic [7:0]  rx_ctrl_r, t1_low_r, retry_t1hi_r, addr_first_r, addr_secnd_r;
	wire         cs_act  = ~bus_s2_r[14];
	wire         wr_act  = cs_act & ~bus_s2_r[13];
	wire         rd_act  = cs_act & ~bus_s2_r[12];
	wire  [3:0]  bus_addr = bus_s2_r[11:8];
	wire  [7:0]  bus_data = bus_s2_r[7:0];
	wire         wr_pulse = wr_act & ~wr_d_r;
	wire  [9:0]  t1_val   = {retry_t1hi_r[T1HI_MSB:0], t1_low_r}; // R9
	wire  [5:0]  retry_lim = retry_t1hi_r[7:RETRY_LSB]; // R9
	logic [7:0]  rd_mux;

	always_comb
	begin
		unique case (bus_addr)
			REG_RX_CTRL:    rd_mux = rx_ctrl_r;
			REG_T1_LOW:     rd_mux = t1_low_r;
			REG_RETRY_T1HI: rd_mux = retry_t1hi_r;
			REG_ADDR_FIRST: rd_mux = addr_first_r;
			REG_ADDR_SECND: rd_mux = addr_secnd_r;
			default:        rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		bus_s1_r <= {CS_N_IN, WE_N_IN, RE_N_IN, ADDR_IN, DAL_IN};
		bus_s2_r <= bus_s1_r;
		if (!RST_N_IN)
		begin
			wr_d_r      <= 1'b0;
			DAL_OUT     <= 8'h00;
			DAL_OE_OUT  <= 1'b0;
			REPLY_N_OUT <= 1'b1;
		end
		else
		begin
			wr_d_r      <= wr_act;
			DAL_OUT     <= rd_act ? rd_mux : 8'h00;
			DAL_OE_OUT  <= rd_act;
			REPLY_N_OUT <= ~(rd_act | wr_act);
		end
	end

	// Writable registers change only by host write or reset
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			t1_low_r     <= REG_RESET_VAL;
			retry_t1hi_r <= REG_RESET_VAL;
			addr_first_r <= REG_RESET_VAL;
			addr_secnd_r <= REG_RESET_VAL;
		end
		else if (wr_pulse)
		begin
			if (bus_addr == REG_T1_LOW)     t1_low_r     <= bus_data; // R11
			if (bus_addr == REG_RETRY_T1HI) retry_t1hi_r <= bus_data; // R11
			if (bus_addr == REG_ADDR_FIRST) addr_first_r <= bus_data;
			if (bus_addr == REG_ADDR_SECND) addr_secnd_r <= bus_data;
		end
	end

	// ***********************************
	// Received frame classification
	// ***********************************
	wire [7:0] rx_c      = RX_EVENT_IN.ctrl;
	wire       addr_match = (RX_EVENT_IN.addr == addr_first_r) | (RX_EVENT_IN.addr == addr_secnd_r); // R17
	wire       rx_v      = RX_EVENT_IN.valid;
	wire       rx_good   = rx_v & addr_match & RX_EVENT_IN.fcs_ok & ~RX_EVENT_IN.short_frame & ~RX_EVENT_IN.aborted;
	wire       rx_cap    = rx_good & ~FRMR_WAIT_IN; // R8
	wire       rx_is_rej = rx_c[3:0] == S_REJ; // R22
	wire       rx_is_rnr = rx_c[3:0] == S_RNR;
	wire       rx_ua_dm  = ((rx_c & CTRL_PF_MASK) == U_UA) | ((rx_c & CTRL_PF_MASK) == U_DM); // R20
	wire       link_up   = ~LINK_DOWN_IN;
	wire       ev_short  = rx_v & RX_EVENT_IN.short_frame; // R3
	wire       ev_fcs    = rx_v & addr_match & (~RX_EVENT_IN.fcs_ok | RX_EVENT_IN.aborted); // R2 R5
	wire       ev_rej_rx = rx_good & rx_is_rej; // R5
	wire       ev_rej_tx = TX_EVENT_IN.sent & (TX_EVENT_IN.kind == FK_REJ);

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			rx_ctrl_r <= REG_RESET_VAL;
		else if (rx_cap)
			rx_ctrl_r <= rx_c; // R8
	end

	// ***********************************
	// Response timer and retries
	// ***********************************
	logic [13:0]  pre_r, pre_nxt;
	logic [9:0]   rem_r, rem_nxt;
	logic [5:0]   retry_r, retry_nxt;
	logic         run_r, run_nxt, idle_s1_r, idle_s2_r, idle_d_r, err_nxt, retx_nxt;
	lapbs_kind_e  kind_r, kind_nxt, retx_kind_nxt;
	wire          tick     = run_r & (pre_r == 14'(TICK_CYCLES - 1)); // R10
	wire          t1_exp   = tick & (rem_r <= 10'h001);
	wire          exp_cmd  = t1_exp & (kind_r != FK_IDLE); // R4
	wire          tx_sent  = TX_EVENT_IN.sent;
	wire  [2:0]   tx_k     = TX_EVENT_IN.kind;

	always_comb
	begin
		run_nxt       = run_r;
		rem_nxt       = rem_r;
		retry_nxt     = retry_r;
		kind_nxt      = kind_r;
		pre_nxt       = run_r ? (tick ? 14'h0000 : pre_r + 14'h0001) : 14'h0000;
		retx_nxt      = 1'b0;
		err_nxt       = 1'b0;
		retx_kind_nxt = kind_r;
		if (tick)
			rem_nxt = rem_r - 10'h001;
		if (t1_exp)
		begin
			rem_nxt  = t1_val;
			retx_nxt = 1'b1;
			if (retry_r < retry_lim)
				retry_nxt = retry_r + 6'h01; // R18
			else
			begin
				err_nxt   = 1'b1; // R18
				retry_nxt = 6'h00;
				if (kind_r == FK_SABM || kind_r == FK_DISC)
					kind_nxt = FK_DISC; // R19
				else
					kind_nxt = FK_SABM; // R19
				retx_kind_nxt = kind_nxt;
			end
		end
		if (tx_sent && !run_r && (tx_k == FK_I || tx_k == FK_S_CMD))
		begin
			run_nxt = 1'b1; // R12
			rem_nxt = t1_val;
			pre_nxt = 14'h0000;
			kind_nxt = lapbs_kind_e'(tx_k);
			if (tx_k == FK_I) retry_nxt = 6'h00; // R12
		end
		if (tx_sent && (tx_k == FK_SABM || tx_k == FK_DISC))
		begin
			run_nxt = 1'b1; // R14
			rem_nxt = t1_val;
			pre_nxt = 14'h0000;
			if (kind_r != lapbs_kind_e'(tx_k)) retry_nxt = 6'h00; // R14
			kind_nxt = lapbs_kind_e'(tx_k);
		end
		if (idle_s2_r && !idle_d_r)
		begin
			run_nxt = 1'b1; // R15
			rem_nxt = t1_val;
			pre_nxt = 14'h0000;
			kind_nxt = FK_IDLE;
		end
		if (ACK_SOME_IN || (rx_good && rx_is_rnr && link_up) || (tx_sent && idle_s2_r))
		begin
			run_nxt   = 1'b1; // R12 R13 R15
			rem_nxt   = t1_val;
			pre_nxt   = 14'h0000;
			retry_nxt = 6'h00;
		end
		if (ACK_ALL_IN || (rx_good && rx_ua_dm) || (!idle_s2_r && idle_d_r))
			run_nxt = 1'b0; // R12 R14 R15
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		idle_s1_r <= RECEIVER_IDLE_FLAG_IN;
		idle_s2_r <= idle_s1_r;
		if (!RST_N_IN)
		begin
			idle_d_r      <= 1'b0;
			run_r         <= 1'b0;
			pre_r         <= 14'h0000;
			rem_r         <= 10'h000;
			retry_r       <= 6'h00;
			kind_r        <= FK_OTHER;
			RETX_REQ_OUT  <= 1'b0;
			RETX_KIND_OUT <= FK_OTHER;
			ERROR_IRQ_OUT <= 1'b0;
		end
		else
		begin
			idle_d_r      <= idle_s2_r;
			run_r         <= run_nxt;
			pre_r         <= pre_nxt;
			rem_r         <= rem_nxt;
			retry_r       <= retry_nxt;
			kind_r        <= kind_nxt;
			RETX_REQ_OUT  <= retx_nxt;
			RETX_KIND_OUT <= retx_kind_nxt;
			ERROR_IRQ_OUT <= err_nxt;
		end
	end

	// ***********************************
	// Error counters through transmit DMA
	// ***********************************
	logic       pend_v_r;
	logic [2:0] pend_idx_r, new_idx;
	lapbs_dma_e dma_st_r;
	wire        new_ev  = link_up & (ev_short | ev_fcs | ev_rej_rx | exp_cmd | ev_rej_tx); // R7
	wire        dma_go  = (dma_st_r == DS_IDLE) & pend_v_r & ~TX_BUSY_IN & link_up; // R7
	wire [7:0]  cnt_inc = (DMA_RDATA_IN == CNT_MAX) ? CNT_MAX : DMA_RDATA_IN + 8'h01; // R1

	always_comb
	begin
		if (ev_short)       new_idx = CNT_SHORT;
		else if (ev_fcs)    new_idx = CNT_FCS;
		else if (ev_rej_rx) new_idx = CNT_REJ_RX;
		else if (exp_cmd)   new_idx = CNT_T1_RUNOUT;
		else                new_idx = CNT_REJ_TX;
	end

	// A newer event overwrites the slot; set wins over the take
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			pend_v_r   <= 1'b0;
			pend_idx_r <= 3'h0;
		end
		else if (new_ev)
		begin
			pend_v_r   <= 1'b1; // R6
			pend_idx_r <= new_idx;
		end
		else if (dma_go)
			pend_v_r <= 1'b0;
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			dma_st_r      <= DS_IDLE;
			DMA_REQ_OUT   <= 1'b0;
			DMA_WE_OUT    <= 1'b0;
			DMA_ADDR_OUT  <= 16'h0000;
			DMA_WDATA_OUT <= 8'h00;
		end
		else
		begin
			unique case (dma_st_r)
				DS_IDLE:
					if (dma_go)
					begin
						dma_st_r     <= DS_RD;
						DMA_REQ_OUT  <= 1'b1;
						DMA_WE_OUT   <= 1'b0;
						DMA_ADDR_OUT <= ERRCNT_BASE + {13'h0000, pend_idx_r} - 16'h0001; // R1
					end
				DS_RD:
					if (DMA_ACK_IN)
					begin
						dma_st_r      <= DS_WR;
						DMA_WE_OUT    <= 1'b1;
						DMA_WDATA_OUT <= cnt_inc; // R1
					end
				DS_WR:
					if (DMA_ACK_IN)
					begin
						dma_st_r    <= DS_IDLE;
						DMA_REQ_OUT <= 1'b0;
						DMA_WE_OUT  <= 1'b0;
					end
				default:
					dma_st_r <= DS_IDLE;
			endcase
		end
	end

	// ***********************************
	// Link side: abort and loop-back
	// ***********************************
	logic       abort_tgl_r, tgl_s1_r, tgl_s2_r, tgl_s3_r, rst_s1_r, rst_s2_r, loop_s1_r, loop_s2_r;
	logic [2:0] abort_cnt_r;
	wire        abort_load = (tgl_s2_r ^ tgl_s3_r) | TX_UNDERRUN_IN; // R23
	wire        line_nxt   = (abort_load | (abort_cnt_r != 3'h0)) ? 1'b1 : TX_DATA_IN;

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			abort_tgl_r <= 1'b0;
		else if (ev_rej_rx && TX_PKT_ACTIVE_IN)
			abort_tgl_r <= ~abort_tgl_r; // R23
		RX_CLK_FROM_TX_OUT <= RST_N_IN & LOOPBACK_SELECT_BIT_IN; // R24
	end

	always_ff @(posedge TX_BIT_CLOCK_IN)
	begin
		rst_s1_r  <= RST_N_IN;
		rst_s2_r  <= rst_s1_r;
		tgl_s1_r  <= abort_tgl_r;
		tgl_s2_r  <= tgl_s1_r;
		loop_s1_r <= LOOPBACK_SELECT_BIT_IN;
		loop_s2_r <= loop_s1_r;
		if (!rst_s2_r)
		begin
			tgl_s3_r           <= 1'b0;
			abort_cnt_r        <= 3'h0;
			SERIAL_TX_LINE_OUT <= 1'b1;
			RX_DATA_OUT        <= 1'b1;
		end
		else
		begin
			tgl_s3_r           <= tgl_s2_r;
			abort_cnt_r        <= abort_load ? ABORT_ONES - 3'h1 : (abort_cnt_r != 3'h0 ? abort_cnt_r - 3'h1 : 3'h0);
			SERIAL_TX_LINE_OUT <= line_nxt;
			RX_DATA_OUT        <= loop_s2_r ? line_nxt : RX_LINE_IN; // R24
		end
	end

	// ***********************************
	// Assertions
	// ***********************************
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);

	a_sat_no_wrap: assert property (dma_st_r == DS_RD && DMA_ACK_IN |=> DMA_WDATA_OUT == // R1
		(($past(DMA_RDATA_IN) == CNT_MAX) ? CNT_MAX : $past(DMA_RDATA_IN) + 8'h01))
		else $error("Counter wrapped past max");
	a_short_count: assert property (ev_short && link_up |=> pend_v_r && pend_idx_r == CNT_SHORT) // R3
		else $error("Short frame not queued");
	a_fcs_count: assert property (rx_v && addr_match && !RX_EVENT_IN.fcs_ok && !ev_short && link_up
		|=> pend_idx_r == CNT_FCS) // R2
		else $error("Check error not queued");
	a_nomatch_skip: assert property (rx_v && !addr_match && !ev_short && !exp_cmd && !ev_rej_tx
		|=> $stable(pend_idx_r)) // R5
		else $error("Unmatched frame counted");
	a_link_down_hold: assert property (LINK_DOWN_IN && dma_st_r == DS_IDLE |=> dma_st_r == DS_IDLE) // R7
		else $error("DMA update while link down");
	a_ctrl_capture: assert property (rx_cap |=> rx_ctrl_r == $past(rx_c)) // R8
		else $error("Control field not captured");
	a_ctrl_ignore: assert property (rx_v && !rx_cap |=> $stable(rx_ctrl_r)) // R8
		else $error("Control field wrongly captured");
	a_timer_kept: assert property (t1_exp && !wr_pulse |=> $stable(t1_val) && $stable(retry_lim)) // R11
		else $error("Timer settings lost on expiry");
	a_retx_poll: assert property (t1_exp && retry_r < retry_lim |=> RETX_REQ_OUT && !ERROR_IRQ_OUT
		&& RETX_KIND_OUT == $past(kind_r)) // R18
		else $error("No poll retransmission");
	a_sabm_to_disc: assert property (t1_exp && retry_r >= retry_lim && kind_r == FK_SABM
		|=> ERROR_IRQ_OUT && RETX_KIND_OUT == FK_DISC) // R19
		else $error("Failed set-mode not followed by disconnect");
	a_ua_stop: assert property (rx_good && rx_ua_dm |=> !run_r) // R14
		else $error("Timer kept running after acknowledge");
	a_i_start: assert property (tx_sent && tx_k == FK_I && !run_r && !ACK_ALL_IN && !(rx_good && rx_ua_dm)
		&& !(idle_d_r && !idle_s2_r) |=> run_r && retry_r == 6'h00 && rem_r == $past(t1_val)) // R12
		else $error("Timer not started by information frame");
	a_abort_ones: assert property (@(posedge TX_BIT_CLOCK_IN) disable iff (!rst_s2_r)
		abort_load |=> SERIAL_TX_LINE_OUT [*7]) // R23
		else $error("Abort shorter than seven ones");
	a_loop_route: assert property (@(posedge TX_BIT_CLOCK_IN) disable iff (!rst_s2_r)
		loop_s2_r |=> RX_DATA_OUT == SERIAL_TX_LINE_OUT) // R24
		else $error("Loop-back data not routed");

	c_counter_write: cover property (dma_st_r == DS_WR && DMA_ACK_IN);
	c_retry_exhaust: cover property (t1_exp && retry_r >= retry_lim);
	c_ctrl_capture:  cover property (rx_cap);
	c_abort_sent:    cover property (@(posedge TX_BIT_CLOCK_IN) abort_load);
endmodule // lapbs_link_supervision

`default_nettype wire

//--- lapbs_pkg.sv
// Shared constants and types of the link supervision block
package lapbs_pkg;
	// ***********************************
	// Register indices on the 4-bit port
	// ***********************************
	localparam logic [3:0] REG_RX_CTRL    = 4'h7;
	localparam logic [3:0] REG_T1_LOW     = 4'h8;
	localparam logic [3:0] REG_RETRY_T1HI = 4'h9;
	localparam logic [3:0] REG_ADDR_FIRST = 4'hE;
	localparam logic [3:0] REG_ADDR_SECND = 4'hF;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	localparam int         RETRY_LSB      = 2;
	localparam int         T1HI_MSB       = 1;

	// ***********************************
	// Timing and counters
	// ***********************************
	localparam int          T1_UNIT_CYCLES = 16384;
	localparam logic [15:0] ERRCNT_BASE    = 16'h0100;
	localparam logic [7:0]  CNT_MAX        = 8'hFF;
	localparam logic [2:0]  CNT_FCS        = 3'h1;
	localparam logic [2:0]  CNT_SHORT      = 3'h2;
	localparam logic [2:0]  CNT_T1_RUNOUT  = 3'h3;
	localparam logic [2:0]  CNT_REJ_RX     = 3'h5;
	localparam logic [2:0]  CNT_REJ_TX     = 3'h6;
	localparam logic [2:0]  ABORT_ONES     = 3'h7;

	// ***********************************
	// Control field codes, poll bit masked
	// ***********************************
	localparam logic [7:0] CTRL_PF_MASK = 8'hEF;
	localparam logic [7:0] U_UA         = 8'h63;
	localparam logic [7:0] U_DM         = 8'h0F;
	localparam logic [3:0] S_RNR        = 4'h5;
	localparam logic [3:0] S_REJ        = 4'h9;

	typedef enum logic [2:0] {
		FK_I      = 3'b000,
		FK_S_CMD  = 3'b001,
		FK_S_RSP  = 3'b010,
		FK_SABM   = 3'b011,
		FK_DISC   = 3'b100,
		FK_REJ    = 3'b101,
		FK_IDLE   = 3'b110,
		FK_OTHER  = 3'b111
	} lapbs_kind_e;

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_RD   = 2'b01,
		DS_WR   = 2'b10
	} lapbs_dma_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] ctrl;
		logic       fcs_ok;
		logic       short_frame;
		logic       aborted;
	} lapbs_rxev_s;

	typedef struct packed {
		logic        sent;
		lapbs_kind_e kind;
	} lapbs_txev_s;
endpackage

//--- lapbs_mem_model.sv
// Shared-memory model that answers the counter DMA
`timescale 1ns/1ps
`default_nettype none
module lapbs_mem_model #(
	parameter int WAIT_CYCLES = 2
) (
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	output logic             ack_out,
	output logic [7:0]       rdata_out
);
	logic [7:0] mem [0:7];
	int         wait_r;

	initial
	begin
		ack_out = 1'b0;
		rdata_out = 8'h5A;
		wait_r = 0;
	end

	// One read then one write per counter, each acked once
	always @(posedge clk_in)
	begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out && wait_r < WAIT_CYCLES)
			wait_r <= wait_r + 1;
		else if (req_in && !ack_out)
		begin
			wait_r <= 0;
			ack_out <= 1'b1;
			if (we_in)
				mem[addr_in[2:0]] <= wdata_in;
			else
				rdata_out <= mem[addr_in[2:0]];
		end
	end
endmodule // lapbs_mem_model
`default_nettype wire

//--- test_lapbs_link_supervision.sv
// Testbench of the link supervision block
`timescale 1ns/1ps
`default_nettype none
module test_lapbs_link_supervision;
	import lapbs_pkg::*;
	typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] r;} lapbs_row_s;
	logic clk, rst_n, cs_n, we_n, re_n, oe, reply_n, ack_some, ack_all, link_down, frmr_wait;
	logic tx_busy, tx_pkt, rx_idle, loop_sel, dma_req, dma_we, dma_ack, retx, err, rxc;
	logic txclk, tx_data, tx_urun, rx_line, ser_tx, rx_data;
	logic [3:0] addr;
	logic [7:0] dal_in, dal_out, dma_wdata, dma_rdata, rd;
	logic [15:0] dma_addr;
	lapbs_rxev_s rx_ev;
	lapbs_txev_s tx_ev;
	lapbs_kind_e retx_kind, kind_at_err;
	int n_fail, checks, cyc, n_retx, n_err, t0, n;
	lapbs_row_s rows [6] = '{'{4'h8, 8'hA5, 8'hA5}, '{4'h9, 8'hFD, 8'hFD}, '{4'hE, 8'h01, 8'h01},
		'{4'hF, 8'h03, 8'h03}, '{4'h7, 8'h55, 8'h00}, '{4'h3, 8'h77, 8'h00}};

	lapbs_link_supervision #(.TICK_CYCLES(8)) u_lapbs_link_supervision (
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n), .WE_N_IN(we_n), .RE_N_IN(re_n),
		.ADDR_IN(addr), .DAL_IN(dal_in), .DAL_OUT(dal_out), .DAL_OE_OUT(oe), .REPLY_N_OUT(reply_n),
		.RX_EVENT_IN(rx_ev), .TX_EVENT_IN(tx_ev), .ACK_SOME_IN(ack_some), .ACK_ALL_IN(ack_all),
		.LINK_DOWN_IN(link_down), .FRMR_WAIT_IN(frmr_wait), .TX_BUSY_IN(tx_busy),
		.TX_PKT_ACTIVE_IN(tx_pkt), .RECEIVER_IDLE_FLAG_IN(rx_idle), .LOOPBACK_SELECT_BIT_IN(loop_sel),
		.DMA_REQ_OUT(dma_req), .DMA_WE_OUT(dma_we), .DMA_ADDR_OUT(dma_addr), .DMA_WDATA_OUT(dma_wdata),
		.DMA_ACK_IN(dma_ack), .DMA_RDATA_IN(dma_rdata), .RETX_REQ_OUT(retx), .RETX_KIND_OUT(retx_kind),
		.ERROR_IRQ_OUT(err), .RX_CLK_FROM_TX_OUT(rxc), .TX_BIT_CLOCK_IN(txclk), .TX_DATA_IN(tx_data),
		.TX_UNDERRUN_IN(tx_urun), .RX_LINE_IN(rx_line), .SERIAL_TX_LINE_OUT(ser_tx), .RX_DATA_OUT(rx_data));

	lapbs_mem_model u_lapbs_mem_model (.clk_in(clk), .req_in(dma_req), .we_in(dma_we),
		.addr_in(dma_addr), .wdata_in(dma_wdata), .ack_out(dma_ack), .rdata_out(dma_rdata));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		txclk = 1'b0;
		#37;
		forever #80 txclk = ~txclk;
	end

	// Cycle count, watchdog and pulse tallies
	always @(posedge clk)
	begin
		cyc++;
		if (retx === 1'b1)
			n_retx++;
		if (err === 1'b1)
		begin
			n_err++;
			kind_at_err = retx_kind;
		end
		if (cyc == 20000)
		begin
			n_fail++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic wait_reply(input logic v);
		int i;
		for (i = 0; i < 20 && reply_n !== v; i++)
			@(negedge clk);
		check(reply_n, v, "reply");
	endtask

	task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		we_n = !wr;
		re_n = wr;
		addr = a;
		dal_in = d;
		wait_reply(1'b0);
		repeat (2) @(negedge clk);
		rd = dal_out;
		if (!wr)
			check(oe, 1'b1, "oe");
		cs_n = 1'b1;
		we_n = 1'b1;
		re_n = 1'b1;
		wait_reply(1'b1);
		repeat (4) @(negedge clk);
	endtask

	task automatic rx_pulse(input logic [7:0] a, input logic [7:0] c, input logic fcs, input logic sh);
		@(negedge clk);
		rx_ev = '{1'b1, a, c, fcs, sh, 1'b0};
		@(negedge clk);
		rx_ev.valid = 1'b0;
	endtask

	task automatic wait_dma();
		int i;
		for (i = 0; i < 60 && dma_req !== 1'b1; i++)
			@(negedge clk);
		for (i = 0; i < 60 && dma_req !== 1'b0; i++)
			@(negedge clk);
		repeat (4) @(negedge clk);
	endtask

	task automatic count_abort();
		n = 0;
		repeat (20)
		begin
			if (ser_tx === 1'b1)
				n++;
			@(negedge txclk);
		end
	endtask

	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		{cs_n, we_n, re_n, rst_n} = 4'hE;
		{ack_some, ack_all, link_down, frmr_wait, tx_busy, tx_pkt, rx_idle, loop_sel} = 8'h00;
		{tx_data, tx_urun, rx_line} = 3'b000;
		addr = 4'h0;
		dal_in = 8'h00;
		rx_ev = '0;
		tx_ev = '{1'b0, FK_OTHER};
		for (n = 0; n < 8; n++)
			u_lapbs_mem_model.mem[n] = 8'h10;
		u_lapbs_mem_model.mem[1] = 8'hFF;
		// Long enough for the link domain to see reset
		repeat (128) @(negedge clk);
		check({dal_out, 7'h00, reply_n}, 16'h0001, "reset outputs");
		check({dma_req, retx, ser_tx}, 3'b001, "reset dma and line");
		rst_n = 1'b1;
		$display("test reset done");
		foreach (rows[i])
		begin
			reg_acc(1'b1, rows[i].a, rows[i].w);
			reg_acc(1'b0, rows[i].a, 8'h00);
			check(rd, rows[i].r, "register row");
		end
		$display("test registers done");
		rx_pulse(8'h01, 8'h20, 1'b1, 1'b0);
		rx_pulse(8'h07, 8'h22, 1'b1, 1'b0);
		frmr_wait = 1'b1;
		rx_pulse(8'h03, 8'h24, 1'b1, 1'b0);
		frmr_wait = 1'b0;
		rx_pulse(8'h03, 8'h26, 1'b1, 1'b1);
		wait_dma();
		reg_acc(1'b0, REG_RX_CTRL, 8'h00);
		check(rd, 8'h20, "control capture");
		check(u_lapbs_mem_model.mem[1], CNT_MAX, "short counter saturates");
		rx_pulse(8'h03, 8'h28, 1'b0, 1'b0);
		wait_dma();
		check(u_lapbs_mem_model.mem[0], 8'h11, "fcs counter");
		rx_pulse(8'h07, 8'h28, 1'b0, 1'b0);
		repeat (40) @(negedge clk);
		check(u_lapbs_mem_model.mem[0], 8'h11, "fcs counter foreign address");
		link_down = 1'b1;
		rx_pulse(8'h01, 8'h28, 1'b0, 1'b0);
		repeat (40) @(negedge clk);
		link_down = 1'b0;
		check(u_lapbs_mem_model.mem[0], 8'h11, "fcs counter link down");
		tx_busy = 1'b1;
		rx_pulse(8'h03, 8'h2A, 1'b0, 1'b0);
		rx_pulse(8'h03, 8'h2A, 1'b1, 1'b1);
		repeat (20) @(negedge clk);
		check(dma_req, 1'b0, "dma held while busy");
		tx_busy = 1'b0;
		wait_dma();
		check(u_lapbs_mem_model.mem[0], 8'h11, "earlier event overwritten");
		$display("test counters done");
		// Timer 2 units, retry limit 1
		reg_acc(1'b1, REG_T1_LOW, 8'h02);
		reg_acc(1'b1, REG_RETRY_T1HI, 8'h04);
		n_retx = 0;
		n_err = 0;
		@(negedge clk);
		tx_ev = '{1'b1, FK_I};
		t0 = cyc;
		@(negedge clk);
		tx_ev.sent = 1'b0;
		for (n = 0; n < 200 && n_retx == 0; n++)
			@(negedge clk);
		check(16'((cyc - t0) >= 16 && (cyc - t0) <= 20), 16'h1, "timer delay");
		check(retx_kind, FK_I, "resent kind");
		wait_dma();
		check(u_lapbs_mem_model.mem[2], 8'h11, "run-out counter");
		for (n = 0; n < 300 && n_err == 0; n++)
			@(negedge clk);
		check(16'(n_retx), 16'h2, "retries before error");
		check(kind_at_err, FK_SABM, "recovery kind");
		rx_pulse(8'h01, U_UA, 1'b1, 1'b0);
		n = n_retx;
		repeat (80) @(negedge clk);
		check(16'(n_retx - n), 16'h0, "timer stopped");
		n_retx = 0;
		rx_idle = 1'b1;
		for (n = 0; n < 100 && n_retx == 0; n++)
			@(negedge clk);
		check(16'(n_retx), 16'h1, "idle run-out");
		check(retx_kind, FK_IDLE, "idle run-out kind");
		rx_idle = 1'b0;
		n = n_retx;
		repeat (60) @(negedge clk);
		check(16'(n_retx - n), 16'h0, "idle stop");
		n_retx = 0;
		@(negedge clk);
		tx_ev = '{1'b1, FK_I};
		@(negedge clk);
		tx_ev.sent = 1'b0;
		repeat (10) @(negedge clk);
		t0 = cyc;
		rx_pulse(8'h01, {4'h0, S_RNR}, 1'b1, 1'b0);
		for (n = 0; n < 200 && n_retx == 0; n++)
			@(negedge clk);
		check(16'((cyc - t0) >= 17 && (cyc - t0) <= 21), 16'h1, "not-ready restart");
		@(negedge clk);
		ack_all = 1'b1;
		@(negedge clk);
		ack_all = 1'b0;
		n = n_retx;
		repeat (60) @(negedge clk);
		check(16'(n_retx - n), 16'h0, "all acknowledged stop");
		reg_acc(1'b0, REG_RETRY_T1HI, 8'h00);
		check(rd, 8'h04, "limit kept");
		$display("test timer done");
		reg_acc(1'b1, REG_ADDR_SECND, 8'h01);
		@(negedge txclk);
		loop_sel = 1'b1;
		rx_line = 1'b1;
		repeat (6) @(negedge txclk);
		check({rx_data, rxc}, 2'b01, "loop low");
		tx_data = 1'b1;
		rx_line = 1'b0;
		repeat (4) @(negedge txclk);
		check(rx_data, 1'b1, "loop high");
		loop_sel = 1'b0;
		repeat (4) @(negedge txclk);
		check({rx_data, rxc}, 2'b00, "external line");
		tx_data = 1'b0;
		repeat (3) @(negedge txclk);
		tx_urun = 1'b1;
		@(negedge txclk);
		tx_urun = 1'b0;
		count_abort();
		check(16'(n), 16'h7, "underrun abort");
		tx_pkt = 1'b1;
		rx_pulse(8'h01, 8'h09, 1'b1, 1'b0);
		count_abort();
		tx_pkt = 1'b0;
		check(16'(n), 16'h7, "reject abort");
		check(u_lapbs_mem_model.mem[4], 8'h11, "reject counter");
		$display("test link done");
		final_report();
	end
endmodule // test_lapbs_link_supervision
`default_nettype wire
